/* File: verilog/led_status_consts.svh */
/*
 * named constants of the status indicator: flash counts,
 * prescale defaults and status word bit positions.
 * assumes inclusion by bare name from the design files.
 */
`ifndef LED_STATUS_CONSTS_SVH
`define LED_STATUS_CONSTS_SVH

// flash timing (ms) at 100 MHz core clock
`define CLK_HZ 100000000
`define FAST_HALF_MS 100
`define SLOW_HALF_MS 400
`define PAUSE_MS 2000
`define BUSY_START_MS 500
`define BUSY_MIN_MS 50
`define BUSY_STEP_MS 50

// counted patterns
`define CNT_PSET 3'h6
`define CNT_PARAM 3'h5
`define CNT_CMD 3'h4
`define CNT_SHADE 3'h3
`define CNT_TRIG 3'h2

// status word bit for internal overvoltage
`define STAT_INT_OV_BIT 22

`endif

/* File: verilog/led_status_pkg.sv */
/*
 * types of the status indicator.
 * assumes led_status_consts.svh is compiled alongside.
 */
package led_status_pkg;

    // what the indicator shows
    typedef enum logic [3:0] {
        SHOW_OFF,
        SHOW_SOLID_ORANGE,
        SHOW_BUSY,
        SHOW_SUPPLY_RED,
        SHOW_SOLID_RED,
        SHOW_FAST_ORANGE,
        SHOW_SLOW_ORANGE,
        SHOW_COUNTED
    } show_e;

    // led colour code: bit0 red, bit1 green, both for orange
    typedef logic [1:0] colour_t;

endpackage

/* File: verilog/led_flash_if.sv */
/*
 * carrier between the selector and the flash timer.
 * assumes one clock shared by both ends.
 */
interface led_flash_if;
    logic [3:0] mode;
    logic [2:0] count;
    logic lit;
    logic pattern_end;

    modport sel (output mode, output count, input lit, input pattern_end);
    modport tmr (input mode, input count, output lit, output pattern_end);
endinterface

/* File: verilog/led_flash_timer.sv */
/*
 * flash timer: prescales the core clock into fast, slow, busy and
 * counted flash waveforms.
 * assumes a change of mode or count restarts the pattern from dark.
 */
`include "led_status_consts.svh"

module led_flash_timer #(
    parameter int unsigned FAST_HALF = `FAST_HALF_MS * (`CLK_HZ / 1000),
    parameter int unsigned SLOW_HALF = `SLOW_HALF_MS * (`CLK_HZ / 1000),
    parameter int unsigned PAUSE = `PAUSE_MS * (`CLK_HZ / 1000),
    parameter int unsigned BUSY_START = `BUSY_START_MS * (`CLK_HZ / 1000),
    parameter int unsigned BUSY_MIN = `BUSY_MIN_MS * (`CLK_HZ / 1000),
    parameter int unsigned BUSY_STEP = `BUSY_STEP_MS * (`CLK_HZ / 1000)
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // selector side
    led_flash_if.tmr flash
);

    logic [31:0] tick_q, tick_d;
    logic [31:0] busy_half_q, busy_half_d;
    logic [3:0] edges_q, edges_d;
    logic lit_q, lit_d;
    logic paused_q, paused_d;
    logic end_q, end_d;
    logic [3:0] mode_q;
    logic [2:0] count_q;
    logic [31:0] half;

    ///////////////////////////////////////////////////////////////////
    // half period for the current mode
    always_comb begin
        case (led_status_pkg::show_e'(flash.mode))
            led_status_pkg::SHOW_SUPPLY_RED: half = FAST_HALF;
            led_status_pkg::SHOW_FAST_ORANGE: half = FAST_HALF;
            led_status_pkg::SHOW_BUSY: half = busy_half_q;
            default: half = SLOW_HALF;
        endcase
    end

    // waveform generation from programmable prescale counts
    always_comb begin
        tick_d = tick_q + 32'h1;
        busy_half_d = busy_half_q;
        edges_d = edges_q;
        lit_d = lit_q;
        paused_d = paused_q;
        end_d = 1'b0;
        if (flash.mode != mode_q || flash.count != count_q) begin
            tick_d = 32'h0;
            edges_d = 4'h0;
            lit_d = 1'b0;
            paused_d = 1'b0;
            busy_half_d = BUSY_START;
        end else if (paused_q) begin
            if (tick_q >= PAUSE - 1) begin // pause longer than a flash
                tick_d = 32'h0;
                paused_d = 1'b0;
                end_d = 1'b1;
            end
        end else if (tick_q >= half - 1) begin
            tick_d = 32'h0;
            lit_d = ~lit_q;
            // busy flashing speeds up each period until the half period is down to BUSY_MIN + BUSY_STEP
            if (flash.mode == 4'(led_status_pkg::SHOW_BUSY) && lit_q &&
                busy_half_q > BUSY_MIN + BUSY_STEP) begin
                busy_half_d = busy_half_q - BUSY_STEP;
            end
            if (flash.mode == 4'(led_status_pkg::SHOW_COUNTED)) begin
                edges_d = edges_q + 4'h1;
                if (edges_q + 4'h1 == {flash.count, 1'b0}) begin
                    edges_d = 4'h0;
                    paused_d = 1'b1;
                end
            end
        end
    end

    // state registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tick_q <= 32'h0;
            busy_half_q <= BUSY_START;
            edges_q <= 4'h0;
            lit_q <= 1'b0;
            paused_q <= 1'b0;
            end_q <= 1'b0;
            mode_q <= 4'h0;
            count_q <= 3'h0;
        end else begin
            tick_q <= tick_d;
            busy_half_q <= busy_half_d;
            edges_q <= edges_d;
            lit_q <= lit_d;
            paused_q <= paused_d;
            end_q <= end_d;
            mode_q <= flash.mode;
            count_q <= flash.count;
        end
    end

    assign flash.lit = lit_q;
    assign flash.pattern_end = end_q;

    // a counted pattern never lights during its pause
    pause_dark_a: assert property (@(posedge core_clk) disable iff (rst)
        paused_q |-> !lit_q) else $error("led lit during pattern pause");

endmodule

/* File: verilog/led_status_indicator.sv */
/*
 * status indicator: picks the highest-priority active condition and
 * drives the two-colour status led with its pattern.
 * assumes condition flags are synchronous levels from the self checks.
 */
`include "led_status_consts.svh"

// Behaviour
// - several active conditions: show only the highest priority one
// - after boot evaluate continuously, flash as soon as an error other than internal overvoltage appears
// - power present, nothing active: steady orange
// - busy operation: flashing at rising rate, stops when done
// - external supply fault: continuous red flashing, priority 1
// - internal overvoltage: steady red, priority 2
// - internal overvoltage reported as status bit 22, one while present
// - general error: fast continuous orange flashing
// - firmware missing or failed load: slow continuous orange flashing
// - faulty parameter set: six slow orange flashes repeated, priority 5
// - invalid parameter: five slow orange flashes repeated, priority 6
// - serial command fault: four slow orange flashes repeated, priority 7
// - shading failure: three flashes, priority 8, cleared by success or reset
// - line rate or trigger stall: two slow orange flashes, priority 9
module led_status_indicator #(
    parameter int unsigned FAST_HALF = `FAST_HALF_MS * (`CLK_HZ / 1000),
    parameter int unsigned SLOW_HALF = `SLOW_HALF_MS * (`CLK_HZ / 1000),
    parameter int unsigned PAUSE = `PAUSE_MS * (`CLK_HZ / 1000),
    parameter int unsigned BUSY_START = `BUSY_START_MS * (`CLK_HZ / 1000),
    parameter int unsigned BUSY_MIN = `BUSY_MIN_MS * (`CLK_HZ / 1000),
    parameter int unsigned BUSY_STEP = `BUSY_STEP_MS * (`CLK_HZ / 1000)
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // boot and power
    input wire logic power_good,
    input wire logic boot_done,
    // condition flags
    input wire logic supply_fault,
    input wire logic int_overvolt,
    input wire logic general_error,
    input wire logic fw_error,
    input wire logic pset_error,
    input wire logic param_error,
    input wire logic cmd_error,
    input wire logic shade_busy,
    input wire logic shade_fail_pulse,
    input wire logic shade_ok_pulse,
    input wire logic line_rate_error,
    input wire logic trigger_stall,
    // status word and led
    output logic [31:0] status_word,
    output logic led_red,
    output logic led_green
);

    led_flash_if flash();

    led_status_pkg::show_e show_q, show_d;
    logic [2:0] count_q, count_d;
    logic shade_fail_q, shade_fail_d;
    logic red_q, red_d;
    logic green_q, green_d;
    logic [31:0] status_q, status_d;

    led_flash_timer #(
        .FAST_HALF(FAST_HALF),
        .SLOW_HALF(SLOW_HALF),
        .PAUSE(PAUSE),
        .BUSY_START(BUSY_START),
        .BUSY_MIN(BUSY_MIN),
        .BUSY_STEP(BUSY_STEP)
    ) u_timer (
        .core_clk(core_clk),
        .rst(rst),
        .flash(flash)
    );

    ///////////////////////////////////////////////////////////////////
    // sticky shading failure, failure wins over success
    always_comb begin
        shade_fail_d = shade_fail_q;
        if (shade_ok_pulse) shade_fail_d = 1'b0;
        if (shade_fail_pulse) shade_fail_d = 1'b1;
    end

    // priority selection, re-evaluated every cycle
    always_comb begin
        show_d = led_status_pkg::SHOW_SOLID_ORANGE;
        count_d = 3'h0;
        if (!power_good) begin
            show_d = led_status_pkg::SHOW_OFF;
        end else if (!boot_done) begin
            show_d = show_q; // boot sequence shown elsewhere
        end else if (supply_fault) begin
            show_d = led_status_pkg::SHOW_SUPPLY_RED;
        end else if (int_overvolt) begin
            show_d = led_status_pkg::SHOW_SOLID_RED;
        end else if (general_error) begin
            show_d = led_status_pkg::SHOW_FAST_ORANGE;
        end else if (fw_error) begin
            show_d = led_status_pkg::SHOW_SLOW_ORANGE;
        end else if (pset_error) begin
            show_d = led_status_pkg::SHOW_COUNTED;
            count_d = `CNT_PSET;
        end else if (param_error) begin
            show_d = led_status_pkg::SHOW_COUNTED;
            count_d = `CNT_PARAM;
        end else if (cmd_error) begin
            show_d = led_status_pkg::SHOW_COUNTED;
            count_d = `CNT_CMD;
        end else if (shade_fail_q) begin
            show_d = led_status_pkg::SHOW_COUNTED;
            count_d = `CNT_SHADE;
        end else if (line_rate_error || trigger_stall) begin
            show_d = led_status_pkg::SHOW_COUNTED;
            count_d = `CNT_TRIG;
        end else if (shade_busy) begin
            show_d = led_status_pkg::SHOW_BUSY;
        end
        status_d = 32'h0;
        status_d[`STAT_INT_OV_BIT] = int_overvolt;
    end

    // led colour from mode and flash waveform
    always_comb begin
        red_d = 1'b0;
        green_d = 1'b0;
        case (show_q)
            led_status_pkg::SHOW_OFF: begin
                red_d = 1'b0;
            end
            led_status_pkg::SHOW_SOLID_ORANGE: begin
                red_d = 1'b1;
                green_d = 1'b1;
            end
            led_status_pkg::SHOW_SUPPLY_RED: begin
                red_d = flash.lit;
            end
            led_status_pkg::SHOW_SOLID_RED: begin
                red_d = 1'b1;
            end
            default: begin
                red_d = flash.lit;
                green_d = flash.lit;
            end
        endcase
    end

    // registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            show_q <= led_status_pkg::SHOW_SOLID_ORANGE;
            count_q <= 3'h0;
            shade_fail_q <= 1'b0;
            red_q <= 1'b0;
            green_q <= 1'b0;
            status_q <= 32'h0;
        end else begin
            show_q <= show_d;
            count_q <= count_d;
            shade_fail_q <= shade_fail_d;
            red_q <= red_d;
            green_q <= green_d;
            status_q <= status_d;
        end
    end

    assign flash.mode = 4'(show_q);
    assign flash.count = count_q;
    assign status_word = status_q;
    assign led_red = red_q;
    assign led_green = green_q;

    ///////////////////////////////////////////////////////////////////
    // checks
    supply_wins_a: assert property (@(posedge core_clk) disable iff (rst)
        power_good && boot_done && supply_fault |=> show_q == led_status_pkg::SHOW_SUPPLY_RED)
        else $error("supply fault not shown first");
    solid_red_a: assert property (@(posedge core_clk) disable iff (rst)
        show_q == led_status_pkg::SHOW_SOLID_RED |=> led_red && !led_green)
        else $error("internal overvoltage not solid red");
    idle_orange_a: assert property (@(posedge core_clk) disable iff (rst)
        show_q == led_status_pkg::SHOW_SOLID_ORANGE |=> led_red && led_green)
        else $error("idle led not orange");
    ov_status_a: assert property (@(posedge core_clk) disable iff (rst)
        status_word[`STAT_INT_OV_BIT] == $past(int_overvolt))
        else $error("status bit does not follow overvoltage");
    pset_count_a: assert property (@(posedge core_clk) disable iff (rst)
        power_good && boot_done && !supply_fault && !int_overvolt && !general_error
        && !fw_error && pset_error |=> count_q == `CNT_PSET)
        else $error("parameter set pattern count wrong");
    cmd_prio_a: assert property (@(posedge core_clk) disable iff (rst)
        power_good && boot_done && cmd_error && !param_error |=> count_q != `CNT_TRIG)
        else $error("command fault lost to lower priority");
    shade_sticky_a: assert property (@(posedge core_clk) disable iff (rst)
        shade_fail_pulse |=> shade_fail_q)
        else $error("shading failure not held");
    trig_count_a: assert property (@(posedge core_clk) disable iff (rst)
        show_d == led_status_pkg::SHOW_COUNTED && count_d == `CNT_TRIG |->
        (line_rate_error || trigger_stall))
        else $error("two-flash pattern without cause");
    back_orange_a: assert property (@(posedge core_clk) disable iff (rst)
        power_good && boot_done && !supply_fault && !int_overvolt && !general_error
        && !fw_error && !pset_error && !param_error && !cmd_error && !shade_fail_q
        && !line_rate_error && !trigger_stall && !shade_busy
        |=> show_q == led_status_pkg::SHOW_SOLID_ORANGE)
        else $error("no return to steady orange");

    // pattern end from the timer, dark and red-only modes, busy cause
    pause_end_a: assert property (@(posedge core_clk) disable iff (rst)
        flash.pattern_end |-> $past(show_q) == led_status_pkg::SHOW_COUNTED && !flash.lit)
        else $error("pattern end outside a counted pause");
    unpowered_dark_a: assert property (@(posedge core_clk) disable iff (rst)
        show_q == led_status_pkg::SHOW_OFF |=> !led_red && !led_green)
        else $error("led lit while unpowered");
    supply_red_a: assert property (@(posedge core_clk) disable iff (rst)
        show_q == led_status_pkg::SHOW_SUPPLY_RED |=> !led_green)
        else $error("supply flashing not red only");
    busy_cause_a: assert property (@(posedge core_clk) disable iff (rst)
        show_q == led_status_pkg::SHOW_BUSY && $past(boot_done) |-> $past(shade_busy))
        else $error("busy flashing without busy operation");

endmodule

/* File: test/led_observer.sv */
/*
 * operator model of the two-colour status led: counts flashes,
 * measures gaps between flashes and groups flashes into bursts.
 * assumes led lines change only on core_clk rising edges.
 */
module led_observer #(
    parameter int unsigned GAP = 30
) (
    // clock and control
    input wire logic core_clk,
    input wire logic clear,
    // led lines
    input wire logic led_red,
    input wire logic led_green,
    // observations
    output logic [7:0] rises,
    output logic [7:0] burst,
    output logic [7:0] first_gap,
    output logic [7:0] last_gap,
    output logic mixed,
    output logic green_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic red_q;
    logic [7:0] gap_q;
    logic [7:0] run_q;

    // edge counting; gap longer than GAP closes a burst
    always_ff @(posedge core_clk) begin
        if (clear) begin
            red_q <= led_red;
            {rises, burst, first_gap, last_gap, gap_q, run_q} <= '0;
            {mixed, green_seen} <= 2'b00;
        end else begin
            red_q <= led_red;
            if (led_red !== led_green) mixed <= 1'b1;
            if (led_green === 1'b1) green_seen <= 1'b1;
            gap_q <= (gap_q == 8'hFF) ? gap_q : gap_q + 8'h01;
            if (led_red && !red_q) begin
                rises <= rises + 8'h01;
                if (rises == 8'h01) first_gap <= gap_q;
                last_gap <= gap_q;
                gap_q <= '0;
                if (gap_q > GAP[7:0]) begin
                    burst <= run_q;
                    run_q <= 8'h01;
                end else begin
                    run_q <= run_q + 8'h01;
                end
            end
        end
    end
endmodule

/* File: test/tb_status_led_priority_indicator.sv */
/*
 * self-checking bench of the status indicator with short timing.
 * assumes flash halves 4/8 cycles, pause 40, busy start 20 step 2.
 */
module tb_status_led_priority_indicator;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0;
    logic rst = 1;
    logic power_good = 1;
    logic boot_done = 1;
    logic [9:0] flags = '0;
    logic fail_p = 0;
    logic ok_p = 0;
    logic clear = 1;
    logic [31:0] status_word;
    logic led_red, led_green, mixed, green_seen;
    logic [7:0] rises, burst, first_gap, last_gap;
    int bad_count = 0;
    int checked = 0;

    always #5 core_clk = ~core_clk;

    led_status_indicator #(.FAST_HALF(4), .SLOW_HALF(8), .PAUSE(40), .BUSY_START(20),
        .BUSY_MIN(2), .BUSY_STEP(2)) led_status_indicator_i (
        .core_clk(core_clk), .rst(rst), .power_good(power_good), .boot_done(boot_done),
        .supply_fault(flags[0]), .int_overvolt(flags[1]), .general_error(flags[2]),
        .fw_error(flags[3]), .pset_error(flags[4]), .param_error(flags[5]),
        .cmd_error(flags[6]), .line_rate_error(flags[7]), .trigger_stall(flags[8]),
        .shade_busy(flags[9]), .shade_fail_pulse(fail_p), .shade_ok_pulse(ok_p),
        .status_word(status_word), .led_red(led_red), .led_green(led_green));

    led_observer led_observer_i (.core_clk(core_clk), .clear(clear), .led_red(led_red),
        .led_green(led_green), .rises(rises), .burst(burst), .first_gap(first_gap),
        .last_gap(last_gap), .mixed(mixed), .green_seen(green_seen));

    ////////////////////////////////////////////////////////////////////////////////
    // compare and drive helpers
    task automatic chk(input logic got, input logic exp, input string msg);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    task automatic chk_rng(input logic [7:0] got, input int lo, input int hi, input string msg);
        checked++;
        if ($isunknown(got) || int'(got) < lo || int'(got) > hi) begin
            bad_count++;
            $display("BAD %0t %s got %0d", $time, msg, got);
        end
    endtask

    task automatic set_flags(input logic [9:0] f);
        @(posedge core_clk);
        flags <= f;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic watch(input int n);
        clear <= 1'b1;
        @(posedge core_clk);
        clear <= 1'b0;
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic solid(input logic red, input logic green, input string msg);
        watch(20);
        chk(led_red, red, msg);
        chk(led_green, green, msg);
        chk_rng(rises, 0, 0, msg);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_idle;
        set_flags('0);
        solid(1'b1, 1'b1, "idle not solid orange");
    endtask

    task automatic t_supply;
        set_flags(10'h007);
        watch(48);
        chk(green_seen, 1'b0, "supply flash not red");
        chk_rng(rises, 5, 7, "supply flash count");
        set_flags(10'h006);
        solid(1'b1, 1'b0, "overvolt not solid red");
        chk(status_word[22], 1'b1, "overvolt status bit");
        set_flags(10'h004);
        watch(64);
        chk_rng(rises, 7, 9, "fast orange count");
        chk(mixed, 1'b0, "fast flash not orange");
        chk(status_word[22], 1'b0, "status bit stuck");
        set_flags(10'h008);
        watch(64);
        chk_rng(rises, 3, 5, "slow orange count");
        chk(mixed, 1'b0, "slow flash not orange");
    endtask

    task automatic t_counted;
        int idx[5] = '{4, 5, 6, 7, 8};
        int cnt[5] = '{6, 5, 4, 2, 2};
        for (int i = 0; i < 5; i++) begin
            set_flags(10'h3F0 & ~((10'h001 << idx[i]) - 10'h001));
            watch(3 * (16 * cnt[i] + 40));
            chk_rng(burst, cnt[i], cnt[i], "counted burst");
            chk(mixed, 1'b0, "counted not orange");
        end
    endtask

    task automatic t_shade;
        set_flags('0);
        fail_p <= 1'b1;
        ok_p <= 1'b1;
        @(posedge core_clk);
        fail_p <= 1'b0;
        ok_p <= 1'b0;
        repeat (3) @(posedge core_clk);
        watch(3 * (16 * 3 + 40));
        chk_rng(burst, 3, 3, "shading failure burst");
        @(posedge core_clk);
        ok_p <= 1'b1;
        @(posedge core_clk);
        ok_p <= 1'b0;
        repeat (3) @(posedge core_clk);
        solid(1'b1, 1'b1, "shading not cleared");
    endtask

    task automatic t_busy;
        set_flags(10'h200);
        watch(300);
        chk_rng(rises, 3, 255, "busy flash count");
        chk(last_gap < first_gap, 1'b1, "busy rate not rising");
        set_flags('0);
        solid(1'b1, 1'b1, "busy flashing not stopped");
    endtask

    task automatic t_power;
        set_flags('0);
        power_good <= 1'b0;
        solid(1'b0, 1'b0, "led lit without power");
        @(posedge core_clk);
        power_good <= 1'b1;
        boot_done <= 1'b0;
        set_flags(10'h001);
        solid(1'b0, 1'b0, "mode not held before boot");
        @(posedge core_clk);
        boot_done <= 1'b1;
        watch(48);
        chk_rng(rises, 5, 7, "no flashing after boot");
        chk(green_seen, 1'b0, "supply flash not red after boot");
        set_flags('0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // verdict, watchdog and main sequence
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #300000;
        bad_count++;
        stop_test();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        t_idle();
        t_supply();
        t_counted();
        t_shade();
        t_busy();
        t_power();
        stop_test();
    end
endmodule
